// ==== las_pkg.sv ====
// Register map, field positions, reset values and timing constants of the serial unit.
`default_nettype none
package las_pkg;
  // ==========================================================================
  // Register byte addresses
  localparam logic [4:0] A_MODE = 5'h00;
  localparam logic [4:0] A_LINE = 5'h04;
  localparam logic [4:0] A_CLK = 5'h08;
  localparam logic [4:0] A_DIV = 5'h0C;
  localparam logic [4:0] A_TXB = 5'h10;
  localparam logic [4:0] A_RXB = 5'h14;
  localparam logic [4:0] A_STAT = 5'h18;
  localparam logic [4:0] A_ROUTE = 5'h1C;
  // ==========================================================================
  // Field positions
  localparam int F_POWER = 7;
  localparam int F_TXE = 6;
  localparam int F_RXE = 5;
  localparam int F_PS = 3;
  localparam int F_CL = 2;
  localparam int F_SL = 1;
  localparam int F_BRKF = 7;
  localparam int F_BRKS = 6;
  localparam int F_BRKM = 5;
  localparam int F_BLEN = 2;
  localparam int F_MSB = 1;
  localparam int F_INV = 0;
  localparam int S_OVE = 2;
  localparam int S_PE = 3;
  localparam int S_FE = 4;
  localparam int R_PIN = 0;
  localparam int R_WAKE = 1;
  localparam int R_CAP = 2;
  // ==========================================================================
  // Reset values and codes
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h10;
  localparam logic [7:0] BUF_RST = 8'hFF;
  localparam logic [3:0] CLK_RST = 4'h0;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  // ==========================================================================
  // Timing counts, in bit times or base-clock ticks
  localparam logic [4:0] BRK_TX_BASE = 5'h0D;
  localparam logic [4:0] BRK_RX_MIN = 5'h0B;
  localparam logic [1:0] GAP_TICKS = 2'h2;
endpackage
`default_nettype wire

// ==== las_serial_unit.sv ====
// Asynchronous serial unit with break send and detect, routing and stop mode.
//
// The address-and-strobe port and the register addresses were decided locally.
`default_nettype none
module las_serial_unit (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_run,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic serial_rx_in_a,
  input wire logic serial_rx_in_b,
  output logic serial_tx_out_a,
  output logic serial_tx_out_b,
  output logic tx_done_event,
  output logic rx_done_event,
  output logic break_rx_event,
  output logic ext_wakeup_irq,
  output logic timer_capture_input
);
  typedef enum logic [6:0] {
    TX_IDLE = 7'b000_0001, TX_START = 7'b000_0010, TX_DATA = 7'b000_0100,
    TX_PAR = 7'b000_1000, TX_STOP = 7'b001_0000, TX_BRK = 7'b010_0000,
    TX_GAP = 7'b100_0000
  } las_tx_st_t;
  typedef enum logic [5:0] {
    RX_IDLE = 6'b00_0001, RX_START = 6'b00_0010, RX_DATA = 6'b00_0100,
    RX_PAR = 6'b00_1000, RX_STOP = 6'b01_0000, RX_BRK = 6'b10_0000
  } las_rx_st_t;

  // ==========================================================================
  // Shared decoding
  function automatic logic par_of(input logic [7:0] d, input logic [1:0] ps);
    if (ps == las_pkg::PAR_ZERO) par_of = 1'b0;
    else if (ps == las_pkg::PAR_ODD) par_of = ~^d;
    else par_of = ^d;
  endfunction

  logic [7:0] mode_ff, line_ctl_ff, div_ff, txb_ff, rxb_ff, rdata_ff;
  logic [3:0] clk_sel_ff;
  logic [2:0] route_ff;
  logic [15:0] pre_cnt_ff;
  logic txe_s_ff, rxe_s_ff, txb_full_ff, rx_full_ff, brk_req_ff, brk_flag_ff;
  logic ove_ff, pe_ff, fe_ff, ev_ove_ff, ev_pe_ff, ev_fe_ff, ev_load_ff;
  las_tx_st_t tx_st_ff;
  las_rx_st_t rx_st_ff;
  logic [7:0] tx_cnt_ff, rx_cnt_ff, tx_sh_ff, rx_sh_ff;
  logic [4:0] tx_bits_ff, rx_bits_ff;
  logic tx_line_ff, tx_par_ff, rx_par_ff;
  logic s1_ff, s2_ff, s3_ff, rx_line_ff, rx_prev_ff;

  wire power = mode_ff[las_pkg::F_POWER];
  wire urst = rst || !power;
  wire [1:0] ps = mode_ff[las_pkg::F_PS +: 2];
  wire cl8 = mode_ff[las_pkg::F_CL];
  wire msb = line_ctl_ff[las_pkg::F_MSB];
  wire brk_mode = line_ctl_ff[las_pkg::F_BRKM];
  wire [4:0] nbits = cl8 ? 5'h08 : 5'h07;
  wire [15:0] pre_lim = ~(16'hFFFF << clk_sel_ff);
  wire base_tick = power && ((pre_cnt_ff & pre_lim) == pre_lim);
  wire [7:0] kk = (div_ff == 8'h00) ? 8'h01 : div_ff;
  wire tx_end = base_tick && (tx_cnt_ff >= kk - 8'h01);
  wire rx_end = base_tick && (rx_cnt_ff >= kk - 8'h01);
  wire rx_mid = base_tick && (rx_cnt_ff >= {1'b0, kk[7:1]});
  wire tx_load = txe_s_ff && ((tx_st_ff == TX_IDLE && !brk_req_ff && txb_full_ff)
    || (tx_st_ff == TX_GAP && base_tick && tx_cnt_ff[1:0] == las_pkg::GAP_TICKS - 2'h1));
  wire brk_take = txe_s_ff && tx_st_ff == TX_IDLE && brk_req_ff;
  wire [7:0] tx_mask = cl8 ? 8'hFF : (msb ? 8'hFE : 8'h7F);
  wire [7:0] tx_nsh = msb ? {tx_sh_ff[6:0], 1'b1} : {1'b1, tx_sh_ff[7:1]};
  wire tx_nbit = msb ? tx_nsh[7] : tx_nsh[0];
  wire [7:0] rx_val = cl8 ? rx_sh_ff
    : (msb ? {rx_sh_ff[6:0], 1'b0} : {1'b0, rx_sh_ff[7:1]});
  wire wr_hit_txb = reg_wr && reg_addr == las_pkg::A_TXB;
  wire rd_hit_rxb = reg_rd && reg_addr == las_pkg::A_RXB;

  // ==========================================================================
  // Base clock prescaler and enable synchronisers
  // Select 0 with divider 80 gives 625 kbps from the 50 MHz clock.
  always_ff @(posedge sys_clk) begin
    if (urst) pre_cnt_ff <= 16'h0000;
    else if (clk_run) pre_cnt_ff <= pre_cnt_ff + 16'h0001;
  end

  // Enables only move on a base tick, so a quick clear-set can be missed.
  always_ff @(posedge sys_clk) begin
    if (urst) begin
      txe_s_ff <= 1'b0;
      rxe_s_ff <= 1'b0;
    end else if (clk_run && base_tick) begin
      txe_s_ff <= mode_ff[las_pkg::F_TXE];
      rxe_s_ff <= mode_ff[las_pkg::F_RXE];
    end
  end

  // ==========================================================================
  // Register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_ff <= las_pkg::MODE_RST;
      line_ctl_ff <= 8'h00;
      clk_sel_ff <= las_pkg::CLK_RST;
      div_ff <= las_pkg::DIV_RST;
      route_ff <= 3'h0;
      txb_ff <= las_pkg::BUF_RST;
    end else if (clk_run && reg_wr) begin
      case (reg_addr)
        las_pkg::A_MODE: mode_ff <= reg_wdata;
        las_pkg::A_LINE: line_ctl_ff <= {2'b00, reg_wdata[5:0]};
        las_pkg::A_CLK: clk_sel_ff <= reg_wdata[3:0];
        las_pkg::A_DIV: div_ff <= reg_wdata;
        las_pkg::A_TXB: txb_ff <= reg_wdata;
        las_pkg::A_ROUTE: route_ff <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // Status flags: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge sys_clk) begin
    if (urst) begin
      txb_full_ff <= 1'b0;
      rx_full_ff <= 1'b0;
      brk_req_ff <= 1'b0;
      brk_flag_ff <= 1'b0;
      ove_ff <= 1'b0;
      pe_ff <= 1'b0;
      fe_ff <= 1'b0;
    end else if (clk_run) begin
      if (wr_hit_txb) txb_full_ff <= 1'b1;
      else if (tx_load) txb_full_ff <= 1'b0;
      if (ev_load_ff) rx_full_ff <= 1'b1;
      else if (rd_hit_rxb) rx_full_ff <= 1'b0;
      if (reg_wr && reg_addr == las_pkg::A_LINE && reg_wdata[las_pkg::F_BRKS]) brk_req_ff <= 1'b1;
      else if (brk_take) brk_req_ff <= 1'b0;
      if (break_rx_event) brk_flag_ff <= 1'b1;
      else if (reg_wr && reg_addr == las_pkg::A_LINE && reg_wdata[las_pkg::F_BRKF])
        brk_flag_ff <= 1'b0;
      if (ev_ove_ff) ove_ff <= 1'b1;
      else if (reg_wr && reg_addr == las_pkg::A_STAT && reg_wdata[las_pkg::S_OVE]) ove_ff <= 1'b0;
      if (ev_pe_ff) pe_ff <= 1'b1;
      else if (reg_wr && reg_addr == las_pkg::A_STAT && reg_wdata[las_pkg::S_PE]) pe_ff <= 1'b0;
      if (ev_fe_ff) fe_ff <= 1'b1;
      else if (reg_wr && reg_addr == las_pkg::A_STAT && reg_wdata[las_pkg::S_FE]) fe_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Register reads: data stand only in the cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (rst) rdata_ff <= 8'h00;
    else if (clk_run) begin
      rdata_ff <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          las_pkg::A_MODE: rdata_ff <= mode_ff;
          las_pkg::A_LINE: rdata_ff <= {brk_flag_ff, brk_req_ff || tx_st_ff == TX_BRK,
            line_ctl_ff[5:0]};
          las_pkg::A_CLK: rdata_ff <= {4'h0, clk_sel_ff};
          las_pkg::A_DIV: rdata_ff <= div_ff;
          las_pkg::A_TXB: rdata_ff <= txb_ff;
          las_pkg::A_RXB: rdata_ff <= rxb_ff;
          las_pkg::A_STAT: rdata_ff <= {2'b00, rx_full_ff, fe_ff, pe_ff, ove_ff, txb_full_ff,
            tx_st_ff != TX_IDLE};
          las_pkg::A_ROUTE: rdata_ff <= {5'h00, route_ff};
          default: rdata_ff <= 8'h00;
        endcase
      end
    end
  end
  assign reg_rdata = rdata_ff;

  // ==========================================================================
  // Transmitter
  always_ff @(posedge sys_clk) begin
    if (urst || !txe_s_ff) begin
      tx_st_ff <= TX_IDLE;
      tx_cnt_ff <= 8'h00;
      tx_bits_ff <= 5'h00;
      tx_sh_ff <= las_pkg::BUF_RST;
      tx_line_ff <= 1'b1;
      tx_par_ff <= 1'b0;
      tx_done_event <= 1'b0;
    end else if (clk_run) begin
      tx_done_event <= 1'b0;
      if (base_tick) tx_cnt_ff <= tx_cnt_ff + 8'h01;
      case (tx_st_ff)
        TX_IDLE: begin
          if (brk_take) begin
            tx_st_ff <= TX_BRK;
            tx_line_ff <= 1'b0;
            tx_cnt_ff <= 8'h00;
            tx_bits_ff <= 5'h00;
          end else if (tx_load) begin
            tx_st_ff <= TX_START;
            tx_sh_ff <= txb_ff;
            tx_par_ff <= par_of(txb_ff & tx_mask, ps);
            tx_line_ff <= 1'b0;
            tx_cnt_ff <= 8'h00;
          end
        end
        TX_START: if (tx_end) begin
          tx_st_ff <= TX_DATA;
          tx_line_ff <= msb ? tx_sh_ff[7] : tx_sh_ff[0];
          tx_bits_ff <= 5'h01;
          tx_cnt_ff <= 8'h00;
        end
        TX_DATA: if (tx_end) begin
          tx_cnt_ff <= 8'h00;
          tx_sh_ff <= tx_nsh;
          if (tx_bits_ff == nbits) begin
            tx_bits_ff <= 5'h00;
            tx_st_ff <= (ps == las_pkg::PAR_NONE) ? TX_STOP : TX_PAR;
            tx_line_ff <= (ps == las_pkg::PAR_NONE) ? 1'b1 : tx_par_ff;
          end else begin
            tx_bits_ff <= tx_bits_ff + 5'h01;
            tx_line_ff <= tx_nbit;
          end
        end
        TX_PAR: if (tx_end) begin
          tx_st_ff <= TX_STOP;
          tx_line_ff <= 1'b1;
          tx_cnt_ff <= 8'h00;
        end
        TX_BRK: if (tx_end) begin
          tx_cnt_ff <= 8'h00;
          if (tx_bits_ff == las_pkg::BRK_TX_BASE + {2'b00, line_ctl_ff[las_pkg::F_BLEN +: 3]}
              - 5'h01) begin
            tx_st_ff <= TX_STOP;
            tx_line_ff <= 1'b1;
            tx_bits_ff <= 5'h00;
          end else tx_bits_ff <= tx_bits_ff + 5'h01;
        end
        TX_STOP: if (tx_end) begin
          tx_cnt_ff <= 8'h00;
          if (mode_ff[las_pkg::F_SL] && tx_bits_ff == 5'h00) tx_bits_ff <= 5'h01;
          else begin
            tx_done_event <= 1'b1;
            tx_st_ff <= txb_full_ff ? TX_GAP : TX_IDLE;
          end
        end
        TX_GAP: if (tx_load) begin
          tx_st_ff <= TX_START;
          tx_sh_ff <= txb_ff;
          tx_par_ff <= par_of(txb_ff & tx_mask, ps);
          tx_line_ff <= 1'b0;
          tx_cnt_ff <= 8'h00;
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Pins: receive input passes three flops; a change counts when two agree.
  always_ff @(posedge sys_clk) begin
    if (urst) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      rx_line_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
      serial_tx_out_a <= 1'b1;
      serial_tx_out_b <= 1'b1;
      ext_wakeup_irq <= 1'b1;
      timer_capture_input <= 1'b1;
    end else if (clk_run) begin
      s1_ff <= route_ff[las_pkg::R_PIN] ? serial_rx_in_b : serial_rx_in_a;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) rx_line_ff <= s3_ff;
      rx_prev_ff <= rx_line_ff;
      // The idle pair stays high so a second transceiver sees no traffic.
      serial_tx_out_a <= route_ff[las_pkg::R_PIN] ? 1'b1
        : tx_line_ff ^ line_ctl_ff[las_pkg::F_INV];
      serial_tx_out_b <= route_ff[las_pkg::R_PIN] ? tx_line_ff ^ line_ctl_ff[las_pkg::F_INV]
        : 1'b1;
      ext_wakeup_irq <= route_ff[las_pkg::R_WAKE] ? rx_line_ff : 1'b1;
      timer_capture_input <= route_ff[las_pkg::R_CAP] ? rx_line_ff : 1'b1;
    end
  end

  // ==========================================================================
  // Receiver
  always_ff @(posedge sys_clk) begin
    if (urst || !rxe_s_ff) begin
      rx_st_ff <= RX_IDLE;
      rx_cnt_ff <= 8'h00;
      rx_bits_ff <= 5'h00;
      rx_sh_ff <= las_pkg::BUF_RST;
      rx_par_ff <= 1'b1;
      rx_done_event <= 1'b0;
      break_rx_event <= 1'b0;
      {ev_ove_ff, ev_pe_ff, ev_fe_ff, ev_load_ff} <= 4'h0;
      if (urst) rxb_ff <= las_pkg::BUF_RST;
    end else if (clk_run) begin
      rx_done_event <= 1'b0;
      break_rx_event <= 1'b0;
      {ev_ove_ff, ev_pe_ff, ev_fe_ff, ev_load_ff} <= 4'h0;
      if (base_tick) rx_cnt_ff <= rx_cnt_ff + 8'h01;
      case (rx_st_ff)
        RX_IDLE: if (rx_prev_ff && !rx_line_ff) begin
          rx_st_ff <= RX_START;
          rx_cnt_ff <= 8'h00;
          rx_sh_ff <= las_pkg::BUF_RST;
        end
        RX_START: if (rx_mid) begin
          rx_cnt_ff <= 8'h00;
          rx_bits_ff <= 5'h01;
          if (rx_line_ff) rx_st_ff <= RX_IDLE;
          else rx_st_ff <= brk_mode ? RX_BRK : RX_DATA;
        end
        RX_DATA: if (rx_end) begin
          rx_cnt_ff <= 8'h00;
          rx_sh_ff <= msb ? {rx_sh_ff[6:0], rx_line_ff} : {rx_line_ff, rx_sh_ff[7:1]};
          if (rx_bits_ff == nbits) rx_st_ff <= (ps == las_pkg::PAR_NONE) ? RX_STOP : RX_PAR;
          else rx_bits_ff <= rx_bits_ff + 5'h01;
        end
        RX_PAR: if (rx_end) begin
          rx_cnt_ff <= 8'h00;
          rx_par_ff <= (ps == las_pkg::PAR_ZERO) || (rx_line_ff == par_of(rx_val, ps));
          rx_st_ff <= RX_STOP;
        end
        RX_STOP: if (rx_end) begin
          rx_st_ff <= RX_IDLE;
          rx_done_event <= 1'b1;
          ev_fe_ff <= !rx_line_ff;
          ev_pe_ff <= !rx_par_ff;
          ev_ove_ff <= rx_full_ff;
          // An overrun keeps the older unread byte.
          if (!rx_full_ff) begin
            rxb_ff <= rx_val;
            ev_load_ff <= 1'b1;
          end
          rx_par_ff <= 1'b1;
        end
        RX_BRK: if (rx_end) begin
          rx_cnt_ff <= 8'h00;
          if (rx_line_ff) begin
            rx_st_ff <= RX_IDLE;
            break_rx_event <= (rx_bits_ff >= las_pkg::BRK_RX_MIN);
          end else if (rx_bits_ff != 5'h1F) rx_bits_ff <= rx_bits_ff + 5'h01;
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_power_off_pins: assert property (clk_run && !power |=>
    serial_tx_out_a && serial_tx_out_b && rx_line_ff)
    else $error("pins not idle while powered off");
  chk_halt_freeze: assert property (!clk_run && !$past(rst) |=>
    $stable(serial_tx_out_a) && $stable(tx_st_ff) && $stable(rxb_ff))
    else $error("state moved while clock halted");
  chk_brk_no_load: assert property (rx_st_ff == RX_BRK |->
    rx_sh_ff == las_pkg::BUF_RST && !ev_load_ff && !ev_fe_ff && !ev_pe_ff && !ev_ove_ff)
    else $error("break mode touched shifter or buffer");
  chk_brk_short_quiet: assert property (rx_st_ff == RX_BRK && rx_end && rx_line_ff
    && rx_bits_ff < las_pkg::BRK_RX_MIN && clk_run |=> !break_rx_event ##1 !$rose(brk_flag_ff))
    else $error("short break was accepted");
  chk_brk_tx_len: assert property (tx_st_ff == TX_BRK |-> !tx_line_ff &&
    tx_bits_ff < las_pkg::BRK_TX_BASE + {2'b00, line_ctl_ff[las_pkg::F_BLEN +: 3]})
    else $error("break field too long");
  chk_done_after_stop: assert property (tx_st_ff == TX_STOP && tx_end && clk_run && power
    && !(mode_ff[las_pkg::F_SL] && tx_bits_ff == 5'h00) |=> tx_done_event && tx_line_ff)
    else $error("no done event after stop");
  chk_gap_b2b: assert property ($past(tx_st_ff) == TX_STOP && $past(txb_full_ff)
    && tx_done_event |-> tx_st_ff == TX_GAP && tx_line_ff)
    else $error("back-to-back frame skipped its gap");
  chk_zero_parity: assert property (tx_st_ff == TX_PAR && ps == las_pkg::PAR_ZERO
    |-> !tx_line_ff)
    else $error("zero parity bit not low");
  chk_en_sync: assert property (power && !base_tick |=> $stable(txe_s_ff) && $stable(rxe_s_ff))
    else $error("enable moved off a base tick");
  chk_start_low: assert property ($rose(tx_st_ff == TX_START) |-> !tx_line_ff
    ##1 tx_st_ff != TX_START || !tx_line_ff)
    else $error("start bit not low");

  cov_break_sent: cover property (tx_st_ff == TX_BRK ##1 tx_st_ff == TX_STOP);
  cov_break_found: cover property (break_rx_event);
  cov_frame_rx: cover property (rx_done_event && ev_load_ff);
  cov_b2b_gap: cover property (tx_st_ff == TX_GAP);
endmodule
`default_nettype wire

// ==== las_partner.sv ====
// Remote serial node model that sends frames and times the line it listens to.
`default_nettype none
module las_partner (
  input wire logic sys_clk,
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_len = 4;
  int lo_run = 0;
  int hi_run = 0;
  int last_low = 0;
  int last_high = 0;
  logic [11:0] got = 12'h000;
  // ========================================
  // Sender
  // The line rests high whenever this node is not sending.
  initial line_out = 1'b1;
  task automatic send_bits(input logic [31:0] pat, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= pat[i];
      repeat (bit_len) @(posedge sys_clk);
    end
    line_out <= 1'b1;
  endtask
  // ========================================
  // Receiver and line timing
  // Sampling mid-bit keeps the capture clear of edge jitter.
  always begin
    @(negedge line_in);
    repeat (bit_len / 2) @(posedge sys_clk);
    for (int i = 0; i < 12; i++) begin
      repeat (bit_len) @(posedge sys_clk);
      got[i] = line_in;
    end
  end
  always @(posedge sys_clk) begin
    if (line_in) begin
      if (lo_run > 0) last_low = lo_run;
      lo_run = 0;
      hi_run++;
    end else begin
      if (hi_run > 0) last_high = hi_run;
      hi_run = 0;
      lo_run++;
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the serial unit against a remote node model.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_run = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sel_b = 1'b0;
  logic inv_view = 1'b0;
  logic [7:0] reg_rdata;
  logic tx_a, tx_b, tx_done, rx_done, brk_ev, wake, cap, p_out;
  int fails = 0;
  int check_count = 0;
  int n_tx = 0;
  int n_rx = 0;
  int n_brk = 0;
  las_serial_unit u_las_serial_unit (.sys_clk(sys_clk), .rst(rst), .clk_run(clk_run),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_rx_in_a(sel_b ? 1'b0 : p_out),
    .serial_rx_in_b(sel_b ? p_out : 1'b0), .serial_tx_out_a(tx_a), .serial_tx_out_b(tx_b),
    .tx_done_event(tx_done), .rx_done_event(rx_done), .break_rx_event(brk_ev),
    .ext_wakeup_irq(wake), .timer_capture_input(cap));
  // The node is told of inversion so that it reads frames as they were meant.
  las_partner u_las_partner (.sys_clk(sys_clk), .line_in((sel_b ? tx_b : tx_a) ^ inv_view),
    .line_out(p_out));
  initial forever #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (tx_done === 1'b1) n_tx++;
    if (rx_done === 1'b1) n_rx++;
    if (brk_ev === 1'b1) n_brk++;
  end
  // ========================================
  // Bus cycles and comparisons
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(32'(reg_rdata & m), 32'(e));
    @(posedge sys_clk);
  endtask
  task automatic wait_ev(input int which, input int n);
    int c;
    c = 0;
    for (int i = 0; i < 3000 && c < n; i++) begin
      @(posedge sys_clk);
      c = (which == 0) ? n_tx : (which == 1) ? n_rx : n_brk;
    end
    if (c < n) begin
      fails++;
      $display("[ERR] %0t ns: event wait ran out", $time);
      test_done();
    end
  endtask
  // Clearing the enables first lets the unit restart each machine from idle.
  task automatic en(input logic [7:0] md);
    wr(las_pkg::A_MODE, 8'h80);
    repeat (2) @(posedge sys_clk);
    wr(las_pkg::A_MODE, md);
    repeat (2) @(posedge sys_clk);
  endtask
  function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] md,
    input logic msb);
    logic [11:0] f;
    logic p;
    int nb;
    f = 12'hFFF;
    p = 1'b0;
    nb = md[las_pkg::F_CL] ? 8 : 7;
    for (int j = 0; j < nb; j++) begin
      f[j] = msb ? d[7 - j] : d[j];
      p ^= f[j];
    end
    case (md[las_pkg::F_PS +: 2])
      2'h1: f[nb] = 1'b0;
      2'h2: f[nb] = ~p;
      2'h3: f[nb] = p;
      default: f[nb] = 1'b1;
    endcase
    return f;
  endfunction
  task automatic send_tx(input logic [7:0] d, input logic [7:0] md, input logic msb);
    int base;
    base = n_tx;
    wr(las_pkg::A_TXB, d);
    wait_ev(0, base + 1);
    repeat (40) @(posedge sys_clk);
    chk(32'(u_las_partner.got), 32'(frame(d, md, msb)));
    chk(n_tx, base + 1);
  endtask
  // ========================================
  // Scenarios
  task automatic s_reset();
    rchk(las_pkg::A_MODE, 8'hFF, las_pkg::MODE_RST);
    rchk(las_pkg::A_DIV, 8'hFF, las_pkg::DIV_RST);
    rchk(las_pkg::A_RXB, 8'hFF, las_pkg::BUF_RST);
    rchk(las_pkg::A_ROUTE, 8'hFF, 8'h00);
    rchk(5'h02, 8'hFF, 8'h00);
    chk(32'({tx_a, wake, cap}), 32'(3'h7));
  endtask
  task automatic s_tx();
    logic [7:0] md [4] = '{8'hC4, 8'hD0, 8'hDE, 8'hCC};
    logic [7:0] dv [4] = '{8'hA5, 8'h3B, 8'h6E, 8'hC1};
    for (int i = 0; i < 4; i++) begin
      u_las_partner.bit_len = (i == 0) ? 8 : 4;
      wr(las_pkg::A_DIV, (i == 0) ? 8'h08 : 8'h04);
      wr(las_pkg::A_LINE, {6'h00, i[0], 1'b0});
      en(md[i]);
      send_tx(dv[i], md[i], i[0]);
    end
  endtask
  task automatic s_gap();
    int base;
    wr(las_pkg::A_LINE, 8'h00);
    for (int s = 0; s < 2; s++) begin
      en({6'h31, s[0], 1'b0});
      base = n_tx;
      wr(las_pkg::A_TXB, 8'h00);
      repeat (4) @(posedge sys_clk);
      wr(las_pkg::A_TXB, 8'h00);
      wait_ev(0, base + 2);
      chk(u_las_partner.last_high, 4 * (1 + s) + las_pkg::GAP_TICKS);
    end
  endtask
  task automatic s_duplex();
    int base;
    base = n_rx;
    en(8'hE4);
    fork
      u_las_partner.send_bits(32'({1'b1, 8'h80, 1'b0}), 10);
      send_tx(8'h96, 8'hE4, 1'b0);
    join
    wait_ev(1, base + 1);
    rchk(las_pkg::A_RXB, 8'hFF, 8'h80);
    u_las_partner.send_bits(32'({1'b0, 8'h55, 1'b0}), 10);
    repeat (20) @(posedge sys_clk);
    rchk(las_pkg::A_STAT, 8'h10, 8'h10);
    wr(las_pkg::A_MODE, 8'h00);
    rchk(las_pkg::A_RXB, 8'hFF, las_pkg::BUF_RST);
    rchk(las_pkg::A_STAT, 8'hFF, 8'h00);
    chk(32'(tx_a), 32'(1'b1));
  endtask
  task automatic s_break();
    int bb;
    int br;
    wr(las_pkg::A_LINE, 8'h20);
    en(8'hA4);
    bb = n_brk;
    br = n_rx;
    u_las_partner.send_bits(32'(8'h00), 10);
    repeat (30) @(posedge sys_clk);
    chk(n_brk, bb);
    u_las_partner.send_bits(32'(8'h00), 11);
    wait_ev(2, bb + 1);
    rchk(las_pkg::A_LINE, 8'hA0, 8'hA0);
    chk(n_rx, br);
    rchk(las_pkg::A_RXB, 8'hFF, las_pkg::BUF_RST);
    rchk(las_pkg::A_STAT, 8'h1C, 8'h00);
    wr(las_pkg::A_MODE, 8'h00);
    wr(las_pkg::A_DIV, 8'h04);
    rchk(las_pkg::A_LINE, 8'hA0, 8'h20);
    en(8'hC4);
    for (int n = 0; n < 8; n += 7) begin
      bb = n_tx;
      wr(las_pkg::A_LINE, {3'h2, n[2:0], 2'h0});
      wait_ev(0, bb + 1);
      repeat (4) @(posedge sys_clk);
      chk(u_las_partner.last_low, (13 + n) * 4);
      chk(n_tx, bb + 1);
    end
  endtask
  task automatic s_route_inv();
    wr(las_pkg::A_ROUTE, 8'h07);
    sel_b <= 1'b1;
    send_tx(8'h3C, 8'hC4, 1'b0);
    chk(32'(tx_a), 32'(1'b1));
    fork
      u_las_partner.send_bits(32'(8'h00), 3);
      begin
        repeat (10) @(posedge sys_clk);
        chk(32'({wake, cap}), 32'(2'h0));
      end
    join
    repeat (10) @(posedge sys_clk);
    chk(32'({wake, cap}), 32'(2'h3));
    wr(las_pkg::A_ROUTE, 8'h00);
    sel_b <= 1'b0;
    wr(las_pkg::A_LINE, 8'h01);
    inv_view <= 1'b1;
    repeat (60) @(posedge sys_clk);
    chk(32'(tx_a), 32'(1'b0));
    send_tx(8'hC3, 8'hC4, 1'b0);
    wr(las_pkg::A_LINE, 8'h00);
    inv_view <= 1'b0;
    repeat (60) @(posedge sys_clk);
  endtask
  task automatic s_stop();
    int base;
    logic v;
    base = n_tx;
    wr(las_pkg::A_TXB, 8'h0F);
    repeat (12) @(posedge sys_clk);
    clk_run <= 1'b0;
    #1 v = tx_a;
    repeat (40) @(posedge sys_clk);
    #1 chk(32'(tx_a), 32'(v));
    chk(n_tx, base);
    @(posedge sys_clk);
    clk_run <= 1'b1;
    @(posedge sys_clk);
    wr(las_pkg::A_MODE, 8'h00);
  endtask
  // ========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    s_reset();
    s_tx();
    s_gap();
    s_duplex();
    s_break();
    s_route_inv();
    s_stop();
    test_done();
  end
endmodule
`default_nettype wire
